// ==== inc/seeh_cfg.svh ====
/*
 Constants for the serial word EEPROM host controller.
 Assumes a 20 MHz system clock; included by bare name.
*/
`ifndef SEEH_CFG_SVH
`define SEEH_CFG_SVH
// Clock rate
`define SEEH_CLK_HZ        20000000
// Link timing, microseconds / milliseconds as printed
`define SEEH_CLK_HI_US     5
`define SEEH_CLK_LO_US     5
`define SEEH_SETUP_US      2
`define SEEH_ERASE_MS      100
`define SEEH_WRITE_MS      10
`define SEEH_SEL_LEAD_US   1
// Derived cycle counts (least times round up)
`define SEEH_HI_CYC   ((`SEEH_CLK_HI_US*`SEEH_CLK_HZ+999999)/1000000)
`define SEEH_LO_CYC   ((`SEEH_CLK_LO_US*`SEEH_CLK_HZ+999999)/1000000)
`define SEEH_SU_CYC   ((`SEEH_SETUP_US*`SEEH_CLK_HZ+999999)/1000000)
`define SEEH_SEL_CYC  ((`SEEH_SEL_LEAD_US*`SEEH_CLK_HZ+999999)/1000000)
`define SEEH_ERASE_CYC ((`SEEH_ERASE_MS*`SEEH_CLK_HZ+999)/1000)
`define SEEH_WRITE_CYC ((`SEEH_WRITE_MS*`SEEH_CLK_HZ+999)/1000)
// Clock pulses per transfer: address, word
`define SEEH_ADDR_BITS 5'h04
`define SEEH_WORD_BITS 5'h10
// Instruction codes {line3,line2,line1}
`define SEEH_OP_ADDR   3'h1
`define SEEH_OP_DIN    3'h5
`define SEEH_OP_DOUT   3'h6
`define SEEH_OP_ERASE  3'h4
`define SEEH_OP_WRITE  3'h2
`define SEEH_OP_READ   3'h3
`define SEEH_OP_STBY   3'h7
// Software register map (index)
`define SEEH_REG_CTRL  2'h0
`define SEEH_REG_ADDR  2'h1
`define SEEH_REG_DATA  2'h2
`define SEEH_REG_STAT  2'h3
// Control command codes
`define SEEH_CMD_READ  2'h1
`define SEEH_CMD_WRITE 2'h2
`define SEEH_CMD_STBY  2'h3
`endif

// ==== inc/seeh_pkg.sv ====
/*
 Types for the serial word EEPROM host controller.
 Assumes seeh_cfg.svh holds all numeric constants.
*/
package seeh_pkg;
   // Sequencer states, one-hot
   typedef enum logic [8:0] {
      SEEH_IDLE  = 9'h001,
      SEEH_SEL   = 9'h002,
      SEEH_SETUP = 9'h004,
      SEEH_HIGH  = 9'h008,
      SEEH_LOW   = 9'h010,
      SEEH_HOLD  = 9'h020,
      SEEH_NEXT  = 9'h040,
      SEEH_END   = 9'h080,
      SEEH_DONE  = 9'h100
   } seeh_state_e;
   // Pins toward the memory
   typedef struct packed {
      logic [2:0] instr;
      logic       clk;
      logic       sel_b;
      logic       dq_o;
      logic       dq_oe;
   } seeh_pins_s;
endpackage

// ==== rtl/seeh_ctrl.sv ====
/*
 Host controller for a 16 x 16 serial EEPROM: sequences address, read,
 data out, data in, word erase and write over the instruction lines.
 Assumes the memory's I/O pin and the hv control pin are sampled here.
*/
`timescale 1ns/1ps
`include "seeh_cfg.svh"
module seeh_ctrl
   import seeh_pkg::*;
#(
   // Hold lengths in clock cycles; defaults give 100 ms and 10 ms
   parameter int ERASE_CYC = `SEEH_ERASE_CYC,
   parameter int WRITE_CYC = `SEEH_WRITE_CYC
)(
   // Clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_ce,
   // Software port
   input  wire logic [1:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   // Memory pins
   output logic [2:0]       o_instr_line,
   output logic             o_mem_clk,
   output logic             o_sel_b,
   output logic             o_serial_addr_data_io_o,
   output logic             o_serial_addr_data_io_oe,
   input  wire logic        i_serial_addr_data_io_i,
   input  wire logic        i_hv_switch_control_out,
   output logic             o_whole_array_erase_pin,
   output logic [1:0]       o_factory_test_pins
);
   // -----------------------------------------------------------------
   // Parameter checks
   // -----------------------------------------------------------------
   // The hold counter is 24 bits wide and counts down to one, so a
   // hold of zero cycles or of 2**24 cycles and more cannot be served.
   // Refused at elaboration rather than silently truncated.
   if (ERASE_CYC < 1) begin : g_erase_short
      $error("seeh_ctrl: ERASE_CYC below one cycle");
   end
   if (ERASE_CYC >= (1 << 24)) begin : g_erase_long
      $error("seeh_ctrl: ERASE_CYC too large for hold counter");
   end
   if (WRITE_CYC < 1) begin : g_write_short
      $error("seeh_ctrl: WRITE_CYC below one cycle");
   end
   if (WRITE_CYC >= (1 << 24)) begin : g_write_long
      $error("seeh_ctrl: WRITE_CYC too large for hold counter");
   end
   // Link phases must fit the same counter
   if (`SEEH_HI_CYC < 1 || `SEEH_LO_CYC < 1) begin : g_phase_bad
      $error("seeh_ctrl: clock phase counts below one cycle");
   end
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   // Everything the block remembers sits in one record, so reset and
   // the clock enable act on all of it at once.
   //  st     sequencer phase within one step
   //  step   which instruction the memory is being given now
   //  last   step after which the command is complete
   //  bits   clock pulses still to give in this step
   //  cnt    cycles left in the current phase or hold
   //  sh     bits going out to, or coming back from, the memory
   //  rword  last word read back, shown in the data register
   //  rdata  read data, changed only by a read strobe
   //  busy, done, hv_seen  status bits shown in STAT
   //  s_dq   pin level resynchronised; only s_dq[1] is ever read
   typedef struct packed {
      seeh_state_e st;
      seeh_pins_s  pins;
      logic [2:0]  step;   // 0 addr,1 read,2 dout,3 din,4 erase,5 write,6 stby
      logic [2:0]  last;   // final step of this command
      logic [4:0]  bits;   // clocks left in this step
      logic [23:0] cnt;
      logic [3:0]  waddr;
      logic [15:0] wdata;
      logic [15:0] rword;
      logic [15:0] sh;
      logic        busy;
      logic        done;
      logic        hv_seen;
      logic [15:0] rdata;
      logic [1:0]  s_dq;   // two-stage sync of data pin
      logic [1:0]  s_hv;
   } seeh_reg_s;
   seeh_reg_s r_q, r_d;
   logic [2:0] op_code;
   logic       s_idle;
   // Code for each step of a sequence
   // Decoded from the step alone, so the lines can be set up in the
   // load phase, well ahead of the rise that latches them; an unused
   // step falls back to the harmless standby code.
   always_comb begin
      case (r_q.step)
         3'h0:    op_code = `SEEH_OP_ADDR;
         3'h1:    op_code = `SEEH_OP_READ;
         3'h2:    op_code = `SEEH_OP_DOUT;
         3'h3:    op_code = `SEEH_OP_DIN;
         3'h4:    op_code = `SEEH_OP_ERASE;
         3'h5:    op_code = `SEEH_OP_WRITE;
         default: op_code = `SEEH_OP_STBY;
      endcase
   end
   assign s_idle = (r_q.st == SEEH_IDLE);
   // -----------------------------------------------------------------
   // Next state: software port, sequencer, pin drive
   // -----------------------------------------------------------------
   // Software registers
   //  CTRL  write 1 read, 2 erase then write, 3 standby; reads back
   //        the low sequencer state bits
   //  ADDR  word address, bits 3:0
   //  DATA  write data going out; reads back the last word read
   //  STAT  bit 0 busy, bit 1 done, bit 2 hv control seen on
   // Writes of any register are dropped while a command runs, so a
   // sequence always sees the address and data it started with.
   // Command step order
   //  read     address, read, data out
   //  write    address, data in, word erase, write
   //  standby  one clock with select high and the standby code
   // The erase always lands on the address just shifted in, which is
   // the same word the write then programs.
   always_comb begin
      r_d = r_q;
      // Both memory pins come from outside this clock; two stages
      // before any logic reads them
      r_d.s_dq = {r_q.s_dq[0], i_serial_addr_data_io_i};
      r_d.s_hv = {r_q.s_hv[0], i_hv_switch_control_out};
      if (r_q.s_hv[1])
         r_d.hv_seen = 1'b1;
      // Read port: data stands the cycle after the strobe
      if (i_rd) begin
         case (i_addr)
            `SEEH_REG_ADDR: r_d.rdata = {12'h000, r_q.waddr};
            `SEEH_REG_DATA: r_d.rdata = r_q.rword;
            `SEEH_REG_STAT: r_d.rdata = {13'h0000, r_q.hv_seen,
                                         r_q.done, r_q.busy};
            default:        r_d.rdata = {13'h0000, r_q.st[2:0]};
         endcase
      end
      if (i_wr && s_idle) begin
         case (i_addr)
            `SEEH_REG_ADDR: r_d.waddr = i_wdata[3:0];
            `SEEH_REG_DATA: r_d.wdata = i_wdata;
            `SEEH_REG_CTRL: begin
               if (i_wdata[1:0] != 2'h0) begin
                  r_d.busy = 1'b1;
                  r_d.done = 1'b0;
                  r_d.st   = SEEH_SEL;
                  r_d.cnt  = 24'(`SEEH_SEL_CYC);
                  case (i_wdata[1:0])
                     `SEEH_CMD_READ:  begin
                        r_d.step = 3'h0;
                        r_d.last = 3'h2;
                     end
                     `SEEH_CMD_WRITE: begin
                        r_d.step = 3'h0;
                        r_d.last = 3'h5;
                     end
                     default: begin
                        r_d.step = 3'h6;
                        r_d.last = 3'h6;
                     end
                  endcase
               end
            end
            default: ;
         endcase
      end
      case (r_q.st)
         // Idle: clock parked low and the shared pin released
         SEEH_IDLE: begin
            r_d.pins.clk   = 1'b0;
            r_d.pins.dq_oe = 1'b0;
         end
         // Select lead time before the first clock edge
         // Select drops first; the first rise comes only after the load
         SEEH_SEL: begin
            r_d.pins.sel_b = 1'b0;
            if (r_q.cnt > 24'h000001)
               r_d.cnt = r_q.cnt - 24'h000001;
            else
               r_d.st = SEEH_NEXT;
         end
         // Load code for a step and its bit count
         SEEH_NEXT: begin
            r_d.pins.instr = op_code;
            // Select goes high only for standby; the standby code then
            // reaches the memory with select high
            r_d.pins.sel_b = (r_q.step == 3'h6);
            case (r_q.step)
               // Address takes four pulses, a word sixteen, the rest one
               3'h0: begin
                  r_d.bits = `SEEH_ADDR_BITS;
                  r_d.sh   = {r_q.waddr, 12'h000};
               end
               3'h2: r_d.bits = `SEEH_WORD_BITS;
               3'h3: begin
                  r_d.bits = `SEEH_WORD_BITS;
                  r_d.sh   = r_q.wdata;
               end
               default: r_d.bits = 5'h01;
            endcase
            r_d.pins.dq_oe = (r_q.step == 3'h0) || (r_q.step == 3'h3);
            r_d.pins.dq_o  = (r_q.step == 3'h0) ? r_q.waddr[3]
                                                : r_q.wdata[15];
            r_d.cnt = 24'(`SEEH_SU_CYC);
            r_d.st  = SEEH_SETUP;
         end
         // Code and data settle before the rising edge
         // Sized for the control and data setup ahead of the rise
         SEEH_SETUP: begin
            if (r_q.cnt > 24'h000001)
               r_d.cnt = r_q.cnt - 24'h000001;
            else begin
               r_d.pins.clk = 1'b1;
               r_d.cnt = 24'(`SEEH_HI_CYC);
               r_d.st  = SEEH_HIGH;
            end
         end
         // Clock high phase within 4 to 10 us
         SEEH_HIGH: begin
            if (r_q.cnt > 24'h000001)
               r_d.cnt = r_q.cnt - 24'h000001;
            else begin
               r_d.pins.clk = 1'b0;
               if (r_q.step == 3'h2)
                  r_d.sh = {r_q.sh[14:0], r_q.s_dq[1]};
               else begin
                  // Next bit moves on the fall: a whole low phase of
                  // setup before the rise that samples it, and no
                  // change at the rise itself
                  r_d.sh        = {r_q.sh[14:0], 1'b0};
                  r_d.pins.dq_o = r_q.sh[14];
               end
               r_d.cnt = 24'(`SEEH_LO_CYC);
               r_d.st  = SEEH_LOW;
            end
         end
         // Clock low phase, then the next rise or the end of the step
         SEEH_LOW: begin
            if (r_q.cnt > 24'h000001)
               r_d.cnt = r_q.cnt - 24'h000001;
            else if (r_q.bits > 5'h01) begin
               r_d.bits = r_q.bits - 5'h01;
               r_d.pins.clk = 1'b1;
               r_d.cnt = 24'(`SEEH_HI_CYC);
               r_d.st  = SEEH_HIGH;
            end else if (r_q.step == 3'h4 || r_q.step == 3'h5) begin
               // Code stays latched while the memory programs
               r_d.cnt = (r_q.step == 3'h4) ? 24'(ERASE_CYC)
                                            : 24'(WRITE_CYC);
               r_d.st  = SEEH_HOLD;
            end else
               r_d.st = SEEH_END;
         end
         // Long hold for erase or write with clock parked low
         // No clock edge may reach the memory until the hold is over
         SEEH_HOLD: begin
            if (r_q.cnt > 24'h000001)
               r_d.cnt = r_q.cnt - 24'h000001;
            else
               r_d.st = SEEH_END;
         end
         // Advance: skip read steps on a write, erase before write
         SEEH_END: begin
            // Release the shared pin between steps
            r_d.pins.dq_oe = 1'b0;
            // The word shows only once all sixteen bits are in
            if (r_q.step == 3'h2)
               r_d.rword = r_q.sh;
            if (r_q.step == r_q.last)
               r_d.st = SEEH_DONE;
            else begin
               r_d.step = (r_q.last == 3'h5 && r_q.step == 3'h0) ? 3'h3
                          : r_q.step + 3'h1;
               r_d.st = SEEH_NEXT;
            end
         end
         // Leave the memory deselected with standby code
         SEEH_DONE: begin
            r_d.pins.instr = `SEEH_OP_STBY;
            r_d.pins.sel_b = 1'b1;
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
            r_d.st   = SEEH_IDLE;
         end
         default: r_d.st = SEEH_IDLE;
      endcase
   end
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   // Reset parks the memory deselected with the standby code and the
   // link clock low; a low clock enable holds every bit, pins included,
   // so the memory simply sees a longer clock phase.
   // Limitation: holding the enable low in the clock high phase can
   // stretch that phase past its upper bound.
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         r_q <= '{st: SEEH_IDLE,
                  pins: '{instr: `SEEH_OP_STBY, clk: 1'b0, sel_b: 1'b1,
                          dq_o: 1'b0, dq_oe: 1'b0},
                  default: '0};
      end else if (i_ce) begin
         r_q <= r_d;
      end
   end
   // Pins come straight from flip-flops
   assign o_rdata                  = r_q.rdata;
   assign o_instr_line             = r_q.pins.instr;
   assign o_mem_clk                = r_q.pins.clk;
   assign o_sel_b                  = r_q.pins.sel_b;
   assign o_serial_addr_data_io_o  = r_q.pins.dq_o;
   assign o_serial_addr_data_io_oe = r_q.pins.dq_oe;
   // Erase-all and factory test inputs stay tied low in normal use
   assign o_whole_array_erase_pin  = 1'b0;
   assign o_factory_test_pins      = 2'h0;
endmodule

// ==== sim/seeh_mem_model.sv ====
/*
 Behavioural model of the 16 x 16 serial EEPROM behind the host block.
 Assumes the host pins arrive directly; it returns the resolved I/O level.
*/
`timescale 1ns/1ps
`include "seeh_cfg.svh"
module seeh_mem_model #(
   parameter int          ER_NS  = 100000000,
   parameter int          WR_NS  = 10000000,
   parameter logic [15:0] ERASED = 16'hFFFF
)(
   // Host pins in, wire level and hv control out
   input  wire logic [2:0] i_instr,
   input  wire logic       i_mclk,
   input  wire logic       i_sel_b,
   input  wire logic       i_host_o,
   input  wire logic       i_host_oe,
   output logic            o_lvl,
   output logic            o_hv
);
   // -----------------------------------------------
   // Array, shifter and latched code
   // -----------------------------------------------
   logic [15:0] mem [16];
   logic [15:0] sr_q  = 16'h0000;
   logic [3:0]  adr_q = 4'h0;
   logic [2:0]  op_q  = `SEEH_OP_STBY;
   logic        flt   = 1'b0;
   real         t0    = 0.0;
   int          errs  = 0;
   // Distinct, asymmetric words so a bit-order slip shows
   initial begin
      for (int i = 0; i < 16; i++)
         mem[i] = {4'(i), 12'hC3A};
   end
   // A released line wanders, so stale data cannot pass by luck
   always #37 flt = ~flt;
   // Drive only in data out and while selected
   assign o_lvl = i_host_oe ? i_host_o :
      (op_q == `SEEH_OP_DOUT && !i_sel_b) ? sr_q[0] : flt;
   assign o_hv = op_q == `SEEH_OP_ERASE || op_q == `SEEH_OP_WRITE;
   // Clock or select rise latches codes, shifts bits and commits any erase or write
   always @(posedge i_mclk or posedge i_sel_b) begin
      if (o_hv && $realtime - t0 < (op_q == `SEEH_OP_ERASE ? ER_NS : WR_NS))
         errs++;
      else begin
         if (o_hv)
            mem[adr_q] = op_q == `SEEH_OP_ERASE ? ERASED : sr_q;
         if (i_sel_b)
            op_q = `SEEH_OP_STBY;
         else begin
            if ((i_instr == `SEEH_OP_WRITE && op_q != `SEEH_OP_ERASE) ||
                (i_instr == `SEEH_OP_READ && op_q == `SEEH_OP_READ))
               errs++;
            case (i_instr)
               `SEEH_OP_ADDR: adr_q = {adr_q[2:0], o_lvl};
               `SEEH_OP_DIN:  sr_q = {sr_q[14:0], o_lvl};
               `SEEH_OP_READ: sr_q = mem[adr_q];
               `SEEH_OP_DOUT: sr_q = {sr_q[14:0], sr_q[15]};
               default:       t0 = $realtime;
            endcase
            op_q = i_instr;
         end
      end
   end
endmodule

// ==== sim/seeh_ctrl_chk.sv ====
/*
 Assertions on the memory-side pins of the serial EEPROM host block.
 Assumes a 20 MHz clock; bound to seeh_ctrl at the foot of this file.
*/
`timescale 1ns/1ps
`include "seeh_cfg.svh"
module seeh_ctrl_chk #(
   parameter int ERASE_CYC = 50,
   parameter int WRITE_CYC = 20
)(
   // Clock, reset and memory pins
   input wire logic       i_clk,
   input wire logic       i_rst_b,
   input wire logic [2:0] o_instr_line,
   input wire logic       o_mem_clk,
   input wire logic       o_sel_b,
   input wire logic       o_serial_addr_data_io_oe,
   input wire logic       o_whole_array_erase_pin
);
   // -----------------------------------------------
   // Phase counters and last latched code
   // -----------------------------------------------
   logic [7:0] hi_q, lo_q;
   logic [2:0] op_q;
   logic       clk_q;
   int         gap_q;
   wire        rise = o_mem_clk && !clk_q && !o_sel_b;
   // Counters saturate so a stuck clock cannot wrap under the bound
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         hi_q  <= 8'h00;
         lo_q  <= 8'hFF;
         op_q  <= `SEEH_OP_STBY;
         clk_q <= 1'b0;
         gap_q <= 0;
      end else begin
         hi_q  <= !o_mem_clk ? 8'h00 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h01);
         lo_q  <= o_mem_clk ? 8'h00 : (lo_q == 8'hFF ? lo_q : lo_q + 8'h01);
         op_q  <= rise ? o_instr_line : op_q;
         clk_q <= o_mem_clk;
         gap_q <= rise ? 0 : gap_q + 1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_long_end;
      rise || $rose(o_sel_b);
   endsequence
   a_erase_pin_low: assert property (!o_whole_array_erase_pin)
      else $error("whole array erase pin raised");
   a_clk_high_len: assert property ($fell(o_mem_clk) |->
      hi_q >= 8'h50 && hi_q <= 8'hC8) else $error("clock high phase");
   a_clk_low_len: assert property (rise |-> lo_q >= 8'h50)
      else $error("clock low phase short");
   a_code_stable: assert property (o_mem_clk |->
      $stable(o_instr_line) && $stable(o_sel_b)) else $error("code moved");
   a_code_legal: assert property (rise |-> o_instr_line inside
      {3'h1, 3'h5, 3'h6, 3'h4, 3'h2, 3'h3}) else $error("bad code");
   a_read_single: assert property (rise && o_instr_line == `SEEH_OP_READ
      |-> op_q != `SEEH_OP_READ) else $error("read held");
   a_erase_first: assert property (rise && o_instr_line == `SEEH_OP_WRITE
      |-> op_q == `SEEH_OP_ERASE) else $error("write without erase");
   a_erase_hold: assert property (s_long_end ##0 op_q == `SEEH_OP_ERASE
      |-> gap_q >= ERASE_CYC - 1) else $error("erase too short");
   a_write_hold: assert property (s_long_end ##0 op_q == `SEEH_OP_WRITE
      |-> gap_q >= WRITE_CYC - 1) else $error("write too short");
   a_host_drives: assert property (rise && o_instr_line inside
      {3'h1, 3'h5} |-> o_serial_addr_data_io_oe) else $error("bit undriven");
   a_no_fight: assert property (rise && o_instr_line == `SEEH_OP_DOUT
      |-> !o_serial_addr_data_io_oe) else $error("host fights data out");
endmodule
bind seeh_ctrl seeh_ctrl_chk #(.ERASE_CYC(ERASE_CYC), .WRITE_CYC(WRITE_CYC))
   u_chk (.i_clk, .i_rst_b, .o_instr_line, .o_mem_clk, .o_sel_b,
   .o_serial_addr_data_io_oe, .o_whole_array_erase_pin);

// ==== sim/tb_seeh_ctrl.sv ====
/*
 Bench for the serial EEPROM host block: register tasks and a memory model.
 Assumes the design, the model and the checker bind are compiled first.
*/
`timescale 1ns/1ps
`include "seeh_cfg.svh"
module tb_seeh_ctrl;
   // -----------------------------------------------
   // Signals, design and memory
   // -----------------------------------------------
   localparam int ER_C = 50;
   localparam int WR_C = 20;
   logic        i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1;
   logic        i_wr = 1'b0, i_rd = 1'b0;
   logic [1:0]  i_addr = 2'h0;
   logic [15:0] i_wdata = 16'h0000, o_rdata, rv;
   logic [2:0]  o_instr_line;
   logic [1:0]  o_factory_test_pins;
   logic        o_mem_clk, o_sel_b, o_whole_array_erase_pin;
   logic        o_serial_addr_data_io_o, o_serial_addr_data_io_oe;
   logic        i_serial_addr_data_io_i, i_hv_switch_control_out;
   int          miscompares = 0, compares = 0;
   seeh_ctrl #(.ERASE_CYC(ER_C), .WRITE_CYC(WR_C)) u_dut (
      .i_clk, .i_rst_b, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_instr_line, .o_mem_clk, .o_sel_b, .o_serial_addr_data_io_o,
      .o_serial_addr_data_io_oe, .i_serial_addr_data_io_i,
      .i_hv_switch_control_out, .o_whole_array_erase_pin,
      .o_factory_test_pins);
   seeh_mem_model #(.ER_NS(ER_C * 50), .WR_NS(WR_C * 50)) u_mem (
      .i_instr(o_instr_line), .i_mclk(o_mem_clk), .i_sel_b(o_sel_b),
      .i_host_o(o_serial_addr_data_io_o),
      .i_host_oe(o_serial_addr_data_io_oe),
      .o_lvl(i_serial_addr_data_io_i), .o_hv(i_hv_switch_control_out));
   initial begin
      forever #25 i_clk = ~i_clk;
   end
   // One-cycle strobes, changed just after the edge
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      @(negedge i_clk);
      rv = o_rdata;
   endtask
   task automatic chk(input string n, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   // Bounded poll of busy; a hang shows as a mismatch
   task automatic idle;
      int n;
      n = 0;
      rd(`SEEH_REG_STAT);
      while (rv[0] !== 1'b0 && n < 4000) begin
         rd(`SEEH_REG_STAT);
         n++;
      end
      chk("busy", {15'h0000, rv[0]}, 16'h0000);
   endtask
   task automatic rd_word(input logic [3:0] a, input logic [15:0] e);
      wr(`SEEH_REG_ADDR, {12'h000, a});
      wr(`SEEH_REG_CTRL, {14'h0000, `SEEH_CMD_READ});
      idle;
      rd(`SEEH_REG_DATA);
      chk("word", rv, e);
   endtask
   task automatic wrap_up;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Run needs about 27000 cycles
   initial begin
      repeat (80000) @(posedge i_clk);
      miscompares++;
      wrap_up;
   end
   // Reset, boundary reads, erase-write, refused write, standby
   initial begin
      repeat (16) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rd(`SEEH_REG_STAT);
      chk("stat", rv, 16'h0000);
      chk("pins", {12'h000, o_instr_line, o_sel_b}, 16'h000F);
      $display("reset test done");
      rd_word(4'h0, 16'h0C3A);
      rd_word(4'hF, 16'hFC3A);
      $display("read test done");
      wr(`SEEH_REG_ADDR, 16'h0009);
      wr(`SEEH_REG_DATA, 16'h1E5B);
      wr(`SEEH_REG_CTRL, {14'h0000, `SEEH_CMD_WRITE});
      idle;
      rd(`SEEH_REG_STAT);
      chk("stat", rv, 16'h0006);
      rd_word(4'h9, 16'h1E5B);
      rd_word(4'h8, 16'h8C3A);
      $display("write test done");
      wr(`SEEH_REG_ADDR, 16'h0002);
      wr(`SEEH_REG_CTRL, {14'h0000, `SEEH_CMD_READ});
      wr(`SEEH_REG_ADDR, 16'h0007);
      idle;
      rd(`SEEH_REG_DATA);
      chk("busy_drop", rv, 16'h2C3A);
      rd(`SEEH_REG_ADDR);
      chk("addr", rv, 16'h0002);
      // Enable low: a write strobe must leave the address untouched
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(`SEEH_REG_ADDR, 16'h000B);
      i_ce <= 1'b1;
      rd(`SEEH_REG_ADDR);
      chk("ce_hold", rv, 16'h0002);
      wr(`SEEH_REG_CTRL, {14'h0000, `SEEH_CMD_STBY});
      idle;
      rv = {8'h00, o_factory_test_pins, o_whole_array_erase_pin,
            o_serial_addr_data_io_oe, o_instr_line, o_sel_b};
      chk("stby", rv, 16'h000F);
      rd(`SEEH_REG_CTRL);
      chk("state", rv, 16'h0001);
      chk("model", u_mem.errs[15:0], 16'h0000);
      $display("standby test done");
      wrap_up;
   end
endmodule
